// ==== hdl/pce_top.sv ====
// Purpose: Twelve-pin configuration, level interrupts and timer event pins
// Assumes: AHB-Lite slave, single word transfers, 25 MHz clock
// Notes: Pin outputs are registered, one cycle behind the registers
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module pce_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Pins
  input wire logic [11:0] pin_in,
  output logic [11:0] pin_out,
  output logic [11:0] pin_oe_out,
  // Precision-time timer side
  input wire logic [1:0] ptp_compare_in,
  output logic ptp_timer_clear_out,
  output logic [1:0] ptp_capture_out,
  // Interrupt
  output logic irq_out
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_b_r;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_b_r <= rst_meta_r;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [1:0] clr_en_r;
  logic [11:0] irq_pol_r;
  logic [1:0] ev_oe_r;
  logic ev_pol9_r;
  logic ev_pol8_r;
  logic [11:0] buf_r;
  logic [11:0] dir_r;
  logic [11:0] data_r;
  logic [12:0] sts_r;
  logic [12:0] sts_nxt;
  logic [12:0] mask_r;

  // ****************************************
  // Bus slave
  // ****************************************
  logic wr_pend_r;
  logic rd_wait_r;
  logic [31:0] addr_r;
  logic [31:0] rdata_nxt;
  logic [11:0] pin_s;

  wire addr_phase = hsel_in & htrans_in[1] & hready_in & (hsize_in == 3'h2);
  wire rd_req = addr_phase & ~hwrite_in;
  wire wr_req = addr_phase & hwrite_in;
  wire sel_cfg = (addr_r == pce_pkg::PCE_OFS_CFG);
  wire sel_dd = (addr_r == pce_pkg::PCE_OFS_DATA_DIR);
  wire sel_sts = (addr_r == pce_pkg::PCE_OFS_IRQ_STS);
  wire sel_mask = (addr_r == pce_pkg::PCE_OFS_IRQ_MASK);
  wire wr_cfg = wr_pend_r & sel_cfg;
  wire wr_dd = wr_pend_r & sel_dd;
  wire wr_mask = wr_pend_r & sel_mask;
  wire rd_sts = rd_wait_r & sel_sts;

  // Reads take one wait state so earlier writes are visible
  assign hreadyout_out = ~rd_wait_r;
  assign hresp_out = 1'b0;

  // Upper config bits stay zero on read
  wire [31:0] cfg_word = {2'h0, clr_en_r, irq_pol_r, ev_oe_r, ev_pol9_r, ev_pol8_r, buf_r};
  wire [31:0] dd_word = {4'h0, dir_r, 4'h0, pin_s};
  assign rdata_nxt = sel_cfg ? cfg_word :
                     sel_dd ? dd_word :
                     sel_sts ? {19'h0, sts_r} :
                     sel_mask ? {19'h0, mask_r} : 32'h0000_0000;

  always_ff @(posedge clk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      wr_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      hrdata_out <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_req;
      rd_wait_r <= rd_req;
      if (addr_phase) begin
        addr_r <= haddr_in;
      end
      if (rd_wait_r) begin
        hrdata_out <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      clr_en_r <= pce_pkg::PCE_RST_CLR_EN;
      irq_pol_r <= pce_pkg::PCE_RST_POL;
      ev_oe_r <= pce_pkg::PCE_RST_EV_OE;
      ev_pol9_r <= pce_pkg::PCE_RST_EV_POL;
      ev_pol8_r <= pce_pkg::PCE_RST_EV_POL;
      buf_r <= pce_pkg::PCE_RST_BUF;
    end else if (wr_cfg) begin
      clr_en_r <= hwdata_in[pce_pkg::PCE_CFG_CLR_EN_LSB +: 2];
      irq_pol_r <= hwdata_in[pce_pkg::PCE_CFG_POL_LSB +: 12];
      ev_oe_r <= hwdata_in[pce_pkg::PCE_CFG_EV_OE_LSB +: 2];
      ev_pol9_r <= hwdata_in[pce_pkg::PCE_CFG_EV_POL9_BIT];
      ev_pol8_r <= hwdata_in[pce_pkg::PCE_CFG_EV_POL8_BIT];
      buf_r <= hwdata_in[pce_pkg::PCE_CFG_BUF_LSB +: 12];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      dir_r <= pce_pkg::PCE_RST_DIR;
      data_r <= pce_pkg::PCE_RST_DATA;
      mask_r <= pce_pkg::PCE_RST_MASK;
    end else begin
      if (wr_dd) begin
        dir_r <= hwdata_in[pce_pkg::PCE_DIR_LSB +: 12];
        data_r <= hwdata_in[pce_pkg::PCE_DATA_LSB +: 12];
      end
      if (wr_mask) begin
        mask_r <= hwdata_in[12:0];
      end
    end
  end

  // ****************************************
  // Pin input path
  // ****************************************
  logic [11:0] pin_prev_r;

  pce_sync #(
    .WIDTH(12)
  ) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_r),
    .d_in(pin_in),
    .q_out(pin_s)
  );

  always_ff @(posedge clk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      pin_prev_r <= 12'h000;
    end else begin
      pin_prev_r <= pin_s;
    end
  end

  // Active level per pin follows its polarity bit
  wire [11:0] pin_act = ~(pin_s ^ irq_pol_r);
  wire [11:0] pin_act_prev = ~(pin_prev_r ^ irq_pol_r);
  // Edge only, so a held level clears once; 40 ns is one sample
  wire [1:0] act_edge98 = pin_act[9:8] & ~pin_act_prev[9:8];
  // Capture pulses are not gated by direction

  // ****************************************
  // Pin output path
  // ****************************************
  wire [11:0] ev_oe_w = {2'h0, ev_oe_r, 8'h00};
  wire [11:0] ev_pol_w = {2'h0, ev_pol9_r, ev_pol8_r, 8'h00};
  wire [11:0] cmp_w = {2'h0, ptp_compare_in, 8'h00};
  logic [11:0] dir_eff;
  logic [11:0] pin_val;
  logic [11:0] pin_out_nxt;
  logic [11:0] pin_oe_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < pce_pkg::PCE_NPINS; gi++) begin : g_pin
      // Event enable overrides direction, not buffer type
      assign dir_eff[gi] = dir_r[gi] | ev_oe_w[gi];
      assign pin_val[gi] = ev_oe_w[gi] ? ~(cmp_w[gi] ^ ev_pol_w[gi]) : data_r[gi];
      assign pin_oe_nxt[gi] = dir_eff[gi] & (~buf_r[gi] | ~pin_val[gi]);
      assign pin_out_nxt[gi] = pin_val[gi] & ~buf_r[gi];
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      pin_out <= 12'h000;
      pin_oe_out <= 12'h000;
    end else begin
      pin_out <= pin_out_nxt;
      pin_oe_out <= pin_oe_nxt;
    end
  end

  // ****************************************
  // Timer clear, capture and interrupts
  // ****************************************
  wire [1:0] tclr_hit = act_edge98 & clr_en_r & ~dir_eff[9:8];
  wire [12:0] sts_set = {|tclr_hit, pin_act};

  // Set wins over the read clear so no event is lost
  // Held levels keep their bit set through a read clear
  assign sts_nxt = (sts_r & ~(rd_sts ? 13'h1fff : 13'h0000)) | sts_set;

  always_ff @(posedge clk_in or negedge rst_b_r) begin
    if (!rst_b_r) begin
      sts_r <= 13'h0000;
      ptp_timer_clear_out <= 1'b0;
      ptp_capture_out <= 2'h0;
    end else begin
      sts_r <= sts_nxt;
      ptp_timer_clear_out <= |tclr_hit;
      ptp_capture_out <= act_edge98;
    end
  end

  assign irq_out = |(sts_r & mask_r);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_r);

  AST_TCLR_FIRES: assert property (
    (clr_en_r[1] && !dir_r[9] && !ev_oe_r[1] && pin_act[9] && !pin_act_prev[9]) |=> ptp_timer_clear_out)
    else $error("Timer clear missing on pin 9 edge");
  AST_TCLR_POL: assert property (
    ptp_timer_clear_out |-> (($past(pin_s[9]) == $past(irq_pol_r[9])) || ($past(pin_s[8]) == $past(irq_pol_r[8]))))
    else $error("Timer clear with inactive pin level");
  AST_TCLR_OUT_BLOCK: assert property (
    (dir_r[8] && $stable(pin_s[9])) |=> !ptp_timer_clear_out)
    else $error("Timer clear from output pin");
  AST_TCLR_EDGE: assert property (
    $stable(pin_s[9:8]) |=> (!ptp_timer_clear_out && ptp_capture_out == 2'h0))
    else $error("Timer clear without an edge");
  AST_IRQ_LEVEL: assert property (
    (pin_s[0] == irq_pol_r[0]) |=> sts_r[0])
    else $error("Level status not set");
  AST_CAPTURE_POL: assert property (
    ptp_capture_out[0] |-> ($past(pin_s[8]) == $past(irq_pol_r[8])))
    else $error("Capture on wrong polarity");
  AST_EV8_DRIVE: assert property (
    (ev_oe_r[0] && !buf_r[8]) |=> (pin_oe_out[8] && pin_out[8] == ($past(ptp_compare_in[0]) ~^ $past(ev_pol8_r))))
    else $error("Pin 8 event level wrong");
  AST_EV9_DIR: assert property (
    (ev_oe_r[1] && !buf_r[9] && !dir_r[9]) |=> pin_oe_out[9])
    else $error("Pin 9 event not driven");
  AST_EV9_OD: assert property (
    (ev_oe_r[1] && buf_r[9]) |=> (!pin_out[9] && pin_oe_out[9] == ($past(ptp_compare_in[1]) ^ $past(ev_pol9_r))))
    else $error("Pin 9 open-drain event wrong");
  AST_OD_DATA: assert property (
    (buf_r[0] && dir_r[0]) |=> (!pin_out[0] && pin_oe_out[0] == !$past(data_r[0])))
    else $error("Open-drain pin 0 wrong");
  AST_DIR_IN: assert property (
    !dir_r[0] |=> !pin_oe_out[0])
    else $error("Input pin driven");
  AST_RSV_ZERO: assert property (
    (rd_wait_r && sel_cfg) |=> (hrdata_out[31:30] == 2'h0 && hreadyout_out))
    else $error("Reserved config bits not zero");
  // Bus timing, register writes, timer clear status, open-drain and pin 9 capture
  AST_RD_ONE_WAIT: assert property (
    rd_req |=> (!hreadyout_out ##1 hreadyout_out))
    else $error("Read wait state wrong");
  AST_WR_NO_WAIT: assert property (
    wr_req |=> hreadyout_out)
    else $error("Write stalled");
  AST_EV_POL_WR: assert property (
    wr_cfg |=> (ev_pol9_r == $past(hwdata_in[pce_pkg::PCE_CFG_EV_POL9_BIT]) &&
                ev_pol8_r == $past(hwdata_in[pce_pkg::PCE_CFG_EV_POL8_BIT])))
    else $error("Event polarity write lost");
  AST_TCLR_STS: assert property (
    ptp_timer_clear_out |-> sts_r[pce_pkg::PCE_STS_TCLR_BIT])
    else $error("Timer clear status not set");
  AST_OD_NO_HIGH: assert property (
    (buf_r != 12'h000) |=> ((pin_out & $past(buf_r)) == 12'h000))
    else $error("Open-drain pin driven high");
  AST_CAPTURE9_POL: assert property (
    ptp_capture_out[1] |-> ($past(pin_s[9]) == $past(irq_pol_r[9])))
    else $error("Pin 9 capture on wrong polarity");

  COV_TCLR: cover property (ptp_timer_clear_out);
  COV_IRQ: cover property (irq_out ##1 !irq_out);
  COV_EV_OD: cover property (ev_oe_r[0] && buf_r[8] ##1 !pin_oe_out[8]);
  COV_RD_WAIT: cover property (rd_req ##1 !hreadyout_out ##1 hreadyout_out);
  COV_CAPTURE9: cover property (ptp_capture_out[1]);

endmodule : pce_top

// ==== hdl/pce_pkg.sv ====
// Purpose: Shared constants for the pin configuration and event output block
// Assumes: 25 MHz system clock, 32-bit AHB-Lite register access
// Notes: Offsets are byte addresses
//
// Functional notes
// - Enabled pin 9/8 input clears timer interrupt
// - Clear input polarity from pin polarity bits
// - Timer clear only while pin is input
// - Clear is edge detected, longer than 40 ns
// - Per-pin polarity sets level interrupt status
// - Pin 9/8 polarity selects capture event polarity
// - Event-output enables route compare events to pins
// - Event-output enable forces pin direction to output
// - Buffer type still applies under event output
// - Pin 9 event polarity bit, reset one
// - Pin 8 event polarity bit, reset one
// - Open-drain drives low on zero, else floats
// - Direction bit: zero input, one output
package pce_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] PCE_OFS_CFG = 32'h0000_01e0;
  localparam logic [31:0] PCE_OFS_DATA_DIR = 32'h0000_01e4;
  localparam logic [31:0] PCE_OFS_IRQ_STS = 32'h0000_01e8;
  localparam logic [31:0] PCE_OFS_IRQ_MASK = 32'h0000_01ec;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int PCE_NPINS = 12;
  localparam int PCE_CFG_CLR_EN_LSB = 28;
  localparam int PCE_CFG_POL_LSB = 16;
  localparam int PCE_CFG_EV_OE_LSB = 14;
  localparam int PCE_CFG_EV_POL9_BIT = 13;
  localparam int PCE_CFG_EV_POL8_BIT = 12;
  localparam int PCE_CFG_BUF_LSB = 0;
  localparam int PCE_DIR_LSB = 16;
  localparam int PCE_DATA_LSB = 0;
  localparam int PCE_STS_W = 13;
  localparam int PCE_STS_TCLR_BIT = 12;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [1:0] PCE_RST_CLR_EN = 2'h0;
  localparam logic [11:0] PCE_RST_POL = 12'h000;
  localparam logic [1:0] PCE_RST_EV_OE = 2'h0;
  localparam logic PCE_RST_EV_POL = 1'b1;
  localparam logic [11:0] PCE_RST_BUF = 12'h000;
  localparam logic [11:0] PCE_RST_DIR = 12'h000;
  localparam logic [11:0] PCE_RST_DATA = 12'h000;
  localparam logic [12:0] PCE_RST_MASK = 13'h0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int PCE_CLK_PERIOD_NS = 40;
  localparam int PCE_TCLR_MIN_NS = 40;
  localparam int PCE_TCLR_MIN_CYC_RAW = (PCE_TCLR_MIN_NS + PCE_CLK_PERIOD_NS - 1) / PCE_CLK_PERIOD_NS;
  localparam int PCE_TCLR_MIN_CYC = (PCE_TCLR_MIN_CYC_RAW < 1) ? 1 : PCE_TCLR_MIN_CYC_RAW;

endpackage : pce_pkg

// ==== hdl/pce_sync.sv ====
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk_in
// Notes: Only the second stage leaves the module
`timescale 1ns/1ps
module pce_sync #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Data
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds nothing but the second
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end

endmodule : pce_sync

// ==== tb/pce_pin_model.sv ====
// Purpose: External circuitry on the twelve pins
// Assumes: Every pin carries a pull-up
// Notes: Bench chooses which pins it drives and to what level
`timescale 1ns/1ps
module pce_pin_model (
  // Design side
  input wire logic [11:0] pin_out_in,
  input wire logic [11:0] pin_oe_in,
  // Bench side
  input wire logic [11:0] ext_en_in,
  input wire logic [11:0] ext_val_in,
  // Resolved wire level
  output logic [11:0] level_out
);
  // Released open-drain pin floats up, never keeps the last value
  // Bench holds every level for at least four cycles, above 40 ns
  always_comb begin
    level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ((ext_en_in & ext_val_in) | ~ext_en_in));
  end
endmodule : pce_pin_model

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the pin configuration block
// Assumes: Single AHB-Lite master, one slave, fixed seed
// Notes: Pin outputs sampled at the falling edge, where settled
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, w, hrdata;
  logic [1:0] htrans = 0, cmp = 0, cap;
  logic [2:0] hsize = 3'h2;
  logic [11:0] pin_lvl, pin_out, pin_oe, pol, lvl, b, d;
  logic [11:0] ext_en = 12'hfff, ext_val = 12'h200;
  logic hrdy, hresp, tclr, irq;
  int num_errors = 0, checks_done = 0, nclr = 0, nc8 = 0, nc9 = 0;
  int s0 = 0, s8 = 0, s9 = 0;

  pce_top dut_u (.clk_in(clk), .rst_b_in(rst_b), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy),
    .hresp_out(hresp), .hrdata_out(hrdata), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe_out(pin_oe),
    .ptp_compare_in(cmp), .ptp_timer_clear_out(tclr), .ptp_capture_out(cap), .irq_out(irq));
  pce_pin_model pin_u (.pin_out_in(pin_out), .pin_oe_in(pin_oe), .ext_en_in(ext_en),
    .ext_val_in(ext_val), .level_out(pin_lvl));

  initial begin
    forever #20 clk = ~clk;
  end

  // Pulses are counted, so a stretched pulse shows as a miscount
  always @(posedge clk) begin
    if (tclr === 1'b1) nclr <= nclr + 1;
    if (cap[0] === 1'b1) nc8 <= nc8 + 1;
    if (cap[1] === 1'b1) nc9 <= nc9 + 1;
  end

  task test_done;
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // One single-word transfer; read data lands in rd
  task bus(input logic [31:0] a, input logic wr, input logic [31:0] wd);
    int n;
    logic r;
    @(posedge clk);
    hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      do begin
        @(negedge clk);
        r = hrdy;
        rd = hrdata;
        @(posedge clk);
        n++;
        if (n > 20) begin
          num_errors++;
          test_done();
        end
      end while (r !== 1'b1);
      if (ph == 0) begin
        htrans <= 2'h0; hsel <= 0; hwdata <= wd;
      end
    end
  endtask : bus

  task wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt

  task pin(input logic [11:0] v);
    @(posedge clk);
    ext_val <= v;
    repeat (3) @(posedge clk);
  endtask : pin

  initial begin
    void'($urandom(32'ha1e4));
    repeat (6) @(posedge clk);
    rst_b <= 1;
    repeat (3) @(posedge clk);
    bus(32'h1e0, 0, 0); chk(rd, 32'h0000_3000);
    bus(32'h1e4, 0, 0); chk(rd & 32'h0fff_0000, 0);
    bus(32'h1f0, 0, 0); chk(rd, 0);
    chk(hresp, 0);
    repeat (4) begin
      w = $urandom;
      bus(32'h1e0, 1, w);
      bus(32'h1e0, 0, 0); chk(rd, w & 32'h3fff_ffff);
    end
    repeat (4) begin
      pol = 12'($urandom); lvl = 12'($urandom);
      @(posedge clk) ext_val <= lvl;
      bus(32'h1e0, 1, {4'h0, pol, 16'h3000});
      wt(5);
      bus(pce_pkg::PCE_OFS_IRQ_STS, 0, 0);
      wt(5);
      bus(pce_pkg::PCE_OFS_IRQ_STS, 0, 0); chk(rd, {20'h0, ~(pol ^ lvl)});
    end
    repeat (4) begin
      b = 12'($urandom); d = 12'($urandom);
      bus(32'h1e0, 1, {16'h0, 4'h3, b});
      bus(32'h1e4, 1, {4'h0, 12'hfff, 4'h0, d});
      wt(2); chk({pin_oe, pin_out}, {8'h0, ~b | ~d, d & ~b});
    end
    bus(32'h1e4, 1, 0);
    repeat (6) begin
      b = 12'($urandom); pol = 12'($urandom);
      @(posedge clk) cmp <= 2'($urandom);
      bus(32'h1e0, 1, {16'h0, 2'b11, pol[1:0], b});
      wt(2);
      d[9:8] = cmp ~^ pol[1:0];
      chk({pin_oe[9:8], pin_out[9:8]}, {~b[9:8] | ~d[9:8], d[9:8] & ~b[9:8]});
    end
    // Pin 8 clears on a rise, pin 9 on a fall
    @(posedge clk) cmp <= 0;
    ext_val <= 12'h200;
    bus(pce_pkg::PCE_OFS_IRQ_MASK, 1, 32'h1000);
    bus(32'h1e0, 1, {4'h3, 12'h100, 16'h3000});
    wt(5);
    bus(pce_pkg::PCE_OFS_IRQ_STS, 0, 0);
    wt(2);
    s0 = nclr; s8 = nc8; s9 = nc9;
    pin(12'h300); pin(12'h000); pin(12'h200);
    wt(4);
    chk(nclr - s0, 2);
    chk(nc8 - s8, 1);
    chk(nc9 - s9, 1);
    chk(irq, 1);
    bus(pce_pkg::PCE_OFS_IRQ_STS, 0, 0); chk(rd[12], 1);
    wt(2); chk(irq, 0);
    // Open-drain output released high still lets the pin be toggled
    bus(32'h1e0, 1, {4'h3, 12'h100, 16'h3100});
    bus(32'h1e4, 1, {4'h0, 12'h100, 16'h0100});
    wt(4);
    s0 = nclr; s8 = nc8;
    pin(12'h300); pin(12'h200);
    wt(4);
    chk(nclr - s0, 0);
    chk(nc8 - s8, 1);
    chk(pin_oe[8], 0);
    test_done();
  end
endmodule : tb
